// ---- core/rfio_pkg.sv ----
// constants, encodings and register map for the reader rf/io serial control block
package rfio_pkg;
	// clock and timing
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          PULSE_UNIT_NS  = 10_000_000;
	localparam int          PULSE_UNIT_CYC = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PCNT_W         = 28;
	// serial characters
	localparam logic [7:0]  CH_SOM         = 8'h23;
	localparam logic [7:0]  CH_CR          = 8'h0d;
	localparam logic [7:0]  CH_XON         = 8'h11;
	localparam logic [7:0]  CH_XOFF        = 8'h13;
	localparam int          CMD_MAX        = 6;
	// register byte offsets
	localparam logic [3:0]  REG_CONFIG     = 4'h0;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [3:0]  REG_CONTROL    = 4'h8;
	localparam logic [3:0]  REG_SERIAL     = 4'hc;
	// values after reset
	localparam logic [3:0]  BAUD_9600      = 4'h4;
	localparam logic [3:0]  STOP_1         = 4'h0;
	localparam logic [3:0]  PARITY_NONE    = 4'h0;
	localparam logic [3:0]  DATA_BITS      = 4'h8;
	localparam logic [3:0]  PULSE_LEN_RST  = 4'h0;
	localparam logic [1:0]  REPORT_RST     = 2'h0;
	localparam logic        CONTROL_RST    = 1'b1;
	// rf transmitter control
	typedef enum logic [1:0] {
		RFIO_RF_INPUT = 2'b00,
		RFIO_RF_OFF   = 2'b01,
		RFIO_RF_ON    = 2'b10,
		RFIO_RF_CW    = 2'b11
	} rfio_rf_e;
	// flow control
	typedef enum logic [1:0] {
		RFIO_FLOW_NONE = 2'b00,
		RFIO_FLOW_SW   = 2'b01,
		RFIO_FLOW_HW   = 2'b10
	} rfio_flow_e;
	// command parser
	typedef enum logic {
		RFIO_PS_IDLE    = 1'b0,
		RFIO_PS_COLLECT = 1'b1
	} rfio_pst_e;
endpackage

// ---- core/rfio_ctrl.sv ----
// reader rf gating, sense i/o and serial setup driven by host serial commands
// How it works
// - rf-by-input follows presence input
// - rf off and rf on commands
// - continuous wave held until rf command
// - no tag reading in continuous wave
// - auxiliary input only reported, never controls
// - change reports use tag report path
// - status query gives control, output, input codes
// - input inversion option, off after reset
// - predefined mode pulses both outputs per tag
// - no pulse in read-all or wiegand
// - pulse length set by command
// - direct output commands leave predefined mode
// - host control stays until predefined command
// - serial defaults 9600 8n1, basic, software flow
// - baud, stop and parity commands
// - serial changes accepted in any mode
// - basic or error correcting protocol select
// - xoff stops, xon resumes transmit
// - cts low stops transmit
// - flow control none, software or hardware
// - start-of-message character opens command
// - command and data mode codes
// - change report selection per input
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
module rfio_ctrl #(
	parameter int PULSE_UNIT = rfio_pkg::PULSE_UNIT_CYC
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// received serial characters
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_valid,
	// pins
	input  wire logic        presence_input,
	input  wire logic        auxiliary_input,
	input  wire logic        cts,
	// tag reader events
	input  wire logic        tag_unique_valid,
	input  wire logic        read_all_mode,
	input  wire logic        wiegand_mode,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// rf and sense outputs
	output logic             rf_enable,
	output logic             rf_cw,
	output logic             tag_read_enable,
	output logic             first_sense_output,
	output logic             second_sense_output,
	// serial setup and transmit gating
	output logic             tx_enable,
	output logic             data_mode,
	output logic             error_correcting_protocol,
	output logic      [3:0]  baud_sel,
	output logic      [3:0]  stop_sel,
	output logic      [3:0]  parity_sel,
	// reports and command results
	output logic             change_report,
	output logic      [1:0]  inputs_true,
	output logic             status_query,
	output logic             out_predefined,
	output logic             cmd_done,
	output logic             cmd_error
);
	import rfio_pkg::*;

	// ascii hex digit to nibble, bit 4 marks a valid digit
	function automatic logic [4:0] hex_nib(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hex_nib = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
			hex_nib = {1'b1, 4'(c[3:0] + 4'h9)};
		end else begin
			hex_nib = 5'h00;
		end
	endfunction

	// length and leading-digit match of a collected command
	function automatic logic cmd_is(input logic [2:0] len, input logic [23:0] word,
			input logic [2:0] want, input logic [2:0] fixed, input logic [23:0] pat);
		logic [23:0] mask;
		mask = ~(24'hffffff >> (5'(fixed) * 5'd4));
		cmd_is = (len == want) && ((word & mask) == pat);
	endfunction

	// reset release through two flops
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// pin synchronisers
	logic [2:0] pin_s1_reg;
	logic [2:0] pin_s2_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {cts, auxiliary_input, presence_input};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// parser and configuration state
	rfio_pst_e   pst_reg;
	rfio_rf_e    rf_mode_reg;
	rfio_flow_e  flow_reg;
	logic [3:0]  nib_reg [CMD_MAX];
	logic [2:0]  len_reg;
	logic        bad_reg;
	logic        exec_reg;
	logic        xoff_reg;
	logic        invert_reg;
	logic        predef_reg;
	logic [1:0]  direct_reg;
	logic [3:0]  pulse_len_reg;
	logic [1:0]  report_sel_reg;
	logic        ecp_reg;
	logic        data_mode_reg;
	logic [3:0]  baud_reg;
	logic [3:0]  stop_reg;
	logic [3:0]  parity_reg;
	logic        accept_reg;
	logic [1:0]  prev_in_reg;
	logic [PCNT_W-1:0] pcnt_reg;

	// character classification
	wire [4:0]  rx_nib     = hex_nib(rx_byte);
	wire        rx_flow    = rx_valid && (rx_byte == CH_XON || rx_byte == CH_XOFF);
	wire        rx_cmd     = rx_valid && accept_reg && !rx_flow;
	wire        rx_som     = rx_cmd && rx_byte == CH_SOM;
	wire        rx_end     = rx_cmd && pst_reg == RFIO_PS_COLLECT && rx_byte == CH_CR;

	// command decode on the cycle after the terminator
	wire [23:0] word       = {nib_reg[0], nib_reg[1], nib_reg[2],
	                          nib_reg[3], nib_reg[4], nib_reg[5]};
	wire [3:0]  arg3       = nib_reg[2];
	wire [3:0]  arg4       = nib_reg[3];
	wire        go         = exec_reg && !bad_reg;
	wire        c_data     = go && cmd_is(len_reg, word, 3'd2, 3'd2, 24'h000000);
	wire        c_cmd      = go && cmd_is(len_reg, word, 3'd2, 3'd2, 24'h010000);
	wire        c_baud     = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h100000);
	wire        c_stop     = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h101000);
	wire        c_par      = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h102000);
	wire        c_status   = go && cmd_is(len_reg, word, 3'd3, 3'd3, 24'h526000);
	wire        c_proto    = go && cmd_is(len_reg, word, 3'd3, 3'd2, 24'h610000)
	                         && arg3 <= 4'h1;
	wire        c_flow     = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h614000)
	                         && arg4 <= 4'h2;
	wire        c_predef   = go && cmd_is(len_reg, word, 3'd3, 3'd3, 24'h621000);
	wire        c_direct   = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h620000)
	                         && arg4 <= 4'h3;
	wire        c_rf       = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h640000)
	                         && arg4 <= 4'h2;
	wire        c_rfin     = go && cmd_is(len_reg, word, 3'd3, 3'd3, 24'h641000);
	wire        c_pulse    = go && cmd_is(len_reg, word, 3'd3, 3'd2, 24'h670000);
	wire        c_inv      = go && cmd_is(len_reg, word, 3'd4, 3'd3, 24'h694000)
	                         && arg4 <= 4'h1;
	wire        c_rep      = go && cmd_is(len_reg, word, 3'd3, 3'd2, 24'h820000)
	                         && arg3 <= 4'h3;
	wire        known      = c_data | c_cmd | c_baud | c_stop | c_par | c_status
	                         | c_proto | c_flow | c_predef | c_direct | c_rf | c_rfin
	                         | c_pulse | c_inv | c_rep;

	// sensed inputs after optional inversion
	wire [1:0]  sensed     = pin_s2_reg[1:0] ^ {2{invert_reg}};
	wire        cts_s      = pin_s2_reg[2];
	wire        is_cw      = rf_mode_reg == RFIO_RF_CW;
	wire        rf_on_next = rf_mode_reg == RFIO_RF_ON || is_cw
	                         || (rf_mode_reg == RFIO_RF_INPUT && sensed[0]);
	wire [1:0]  in_change  = (sensed ^ prev_in_reg) & report_sel_reg;
	wire        rep_next   = data_mode_reg && (in_change != 2'b00);
	wire        tag_hit    = tag_unique_valid && predef_reg && !read_all_mode
	                         && !wiegand_mode && !is_cw;
	wire [PCNT_W-1:0] pload = PCNT_W'((32'(pulse_len_reg) + 32'd1) * 32'(PULSE_UNIT));
	wire        pulse_on   = pcnt_reg != '0;
	wire        tx_next    = flow_reg == RFIO_FLOW_SW ? !xoff_reg
	                         : flow_reg == RFIO_FLOW_HW ? cts_s : 1'b1;

	// register port decode
	wire        wr_ctl     = reg_wr && reg_addr == REG_CONTROL;
	wire [31:0] cfg_word   = {16'h0, data_mode_reg, flow_reg, ecp_reg, pulse_len_reg,
	                          report_sel_reg, direct_reg, predef_reg, invert_reg, rf_mode_reg};
	wire [31:0] sta_word   = {24'h0, xoff_reg, tx_enable, rf_enable,
	                          second_sense_output, first_sense_output, pulse_on, sensed};
	wire [31:0] ser_word   = {16'h0, DATA_BITS, parity_reg, stop_reg, baud_reg};
	wire [31:0] rd_word    = reg_addr == REG_CONFIG  ? cfg_word
	                       : reg_addr == REG_STATUS  ? sta_word
	                       : reg_addr == REG_CONTROL ? {31'h0, accept_reg}
	                       : reg_addr == REG_SERIAL  ? ser_word : 32'h0;

	// character collection between start-of-message and terminator
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pst_reg  <= RFIO_PS_IDLE;
			len_reg  <= 3'd0;
			bad_reg  <= 1'b0;
			exec_reg <= 1'b0;
			for (int i = 0; i < CMD_MAX; i++) begin
				nib_reg[i] <= 4'h0;
			end
		end else begin
			exec_reg <= rx_end;
			if (rx_som) begin
				pst_reg <= RFIO_PS_COLLECT;
				len_reg <= 3'd0;
				bad_reg <= 1'b0;
				for (int i = 0; i < CMD_MAX; i++) begin
					nib_reg[i] <= 4'h0;
				end
			end else if (rx_end) begin
				pst_reg <= RFIO_PS_IDLE;
			end else if (rx_cmd && pst_reg == RFIO_PS_COLLECT) begin
				if (rx_nib[4] && len_reg < 3'(CMD_MAX)) begin
					nib_reg[len_reg] <= rx_nib[3:0];
					len_reg          <= len_reg + 3'd1;
				end else begin
					bad_reg <= 1'b1;
				end
			end
		end
	end

	// rf, sense output and report configuration
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rf_mode_reg    <= RFIO_RF_INPUT;
			invert_reg     <= 1'b0;
			predef_reg     <= 1'b1;
			direct_reg     <= 2'b00;
			pulse_len_reg  <= PULSE_LEN_RST;
			report_sel_reg <= REPORT_RST;
			data_mode_reg  <= 1'b1;
		end else begin
			if (c_rf) begin
				rf_mode_reg <= rfio_rf_e'(arg4 == 4'h0 ? RFIO_RF_OFF
				             : arg4 == 4'h1 ? RFIO_RF_ON : RFIO_RF_CW);
			end else if (c_rfin) begin
				rf_mode_reg <= RFIO_RF_INPUT;
			end
			if (c_inv) begin
				invert_reg <= arg4[0];
			end
			if (c_direct) begin
				predef_reg <= 1'b0;
				direct_reg <= {arg4 == 4'h1 || arg4 == 4'h3,
				               arg4 == 4'h2 || arg4 == 4'h3};
			end else if (c_predef) begin
				predef_reg <= 1'b1;
			end
			if (c_pulse) begin
				pulse_len_reg <= arg3;
			end
			if (c_rep) begin
				report_sel_reg <= arg3[1:0];
			end
			if (c_data) begin
				data_mode_reg <= 1'b1;
			end else if (c_cmd) begin
				data_mode_reg <= 1'b0;
			end
		end
	end

	// serial port, protocol and flow control settings
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			baud_reg   <= BAUD_9600;
			stop_reg   <= STOP_1;
			parity_reg <= PARITY_NONE;
			ecp_reg    <= 1'b0;
			flow_reg   <= RFIO_FLOW_SW;
			xoff_reg   <= 1'b0;
		end else begin
			if (c_baud) begin
				baud_reg <= arg4;
			end
			if (c_stop) begin
				stop_reg <= arg4;
			end
			if (c_par) begin
				parity_reg <= arg4;
			end
			if (c_proto) begin
				ecp_reg <= arg3[0];
			end
			if (c_flow) begin
				flow_reg <= rfio_flow_e'(arg4[1:0]);
			end
			// a flow character in the same cycle as a flow command still lands
			if (rx_flow && flow_reg == RFIO_FLOW_SW) begin
				xoff_reg <= rx_byte == CH_XOFF;
			end else if (c_flow) begin
				xoff_reg <= 1'b0;
			end
		end
	end

	// sense output pulse timer and input history
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pcnt_reg    <= '0;
			prev_in_reg <= 2'b00;
		end else begin
			prev_in_reg <= sensed;
			if (!predef_reg) begin
				pcnt_reg <= '0;
			end else if (tag_hit) begin
				pcnt_reg <= pload;
			end else if (pulse_on) begin
				pcnt_reg <= pcnt_reg - PCNT_W'(1);
			end
		end
	end

	// register port
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			accept_reg <= CONTROL_RST;
			reg_rdata  <= 32'h0;
		end else begin
			if (wr_ctl) begin
				accept_reg <= reg_wdata[0];
			end
			reg_rdata <= reg_rd ? rd_word : 32'h0;
		end
	end

	// registered outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rf_enable                 <= 1'b0;
			rf_cw                     <= 1'b0;
			tag_read_enable           <= 1'b0;
			first_sense_output        <= 1'b0;
			second_sense_output       <= 1'b0;
			tx_enable                 <= 1'b0;
			data_mode                 <= 1'b0;
			error_correcting_protocol <= 1'b0;
			baud_sel                  <= BAUD_9600;
			stop_sel                  <= STOP_1;
			parity_sel                <= PARITY_NONE;
			change_report             <= 1'b0;
			inputs_true               <= 2'b00;
			status_query              <= 1'b0;
			out_predefined            <= 1'b1;
			cmd_done                  <= 1'b0;
			cmd_error                 <= 1'b0;
		end else begin
			rf_enable                 <= rf_on_next;
			rf_cw                     <= is_cw;
			tag_read_enable           <= data_mode_reg && !is_cw;
			first_sense_output        <= predef_reg ? pulse_on : direct_reg[0];
			second_sense_output       <= predef_reg ? pulse_on : direct_reg[1];
			tx_enable                 <= tx_next;
			data_mode                 <= data_mode_reg;
			error_correcting_protocol <= ecp_reg;
			baud_sel                  <= baud_reg;
			stop_sel                  <= stop_reg;
			parity_sel                <= parity_reg;
			change_report             <= rep_next;
			inputs_true               <= sensed;
			status_query              <= c_status;
			out_predefined            <= predef_reg;
			cmd_done                  <= known;
			cmd_error                 <= exec_reg && !known;
		end
	end
endmodule // rfio_ctrl

// ---- testbench/rfio_ctrl_asserts.sv ----
// concurrent checks on the rf/io serial control ports
`timescale 1ns/10ps
module rfio_ctrl_asserts (
	// clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// inputs watched
	input wire logic [7:0]  rx_byte,
	input wire logic        rx_valid,
	input wire logic        tag_unique_valid,
	input wire logic        read_all_mode,
	input wire logic        wiegand_mode,
	input wire logic        reg_rd,
	// outputs watched
	input wire logic [31:0] reg_rdata,
	input wire logic        rf_enable,
	input wire logic        rf_cw,
	input wire logic        tag_read_enable,
	input wire logic        first_sense_output,
	input wire logic        second_sense_output,
	input wire logic        data_mode,
	input wire logic        change_report,
	input wire logic        out_predefined,
	input wire logic        cmd_done,
	input wire logic        cmd_error
);
	import rfio_pkg::*;
	// carriage return seen on the serial input
	wire logic cr_seen = rx_valid && (rx_byte == CH_CR);
	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_cw_rf; rf_cw |-> rf_enable; endproperty
	a_cw_rf: assert property (p_cw_rf) else $error("cw without rf");
	property p_cw_notag; rf_cw |-> !tag_read_enable; endproperty
	a_cw_notag: assert property (p_cw_notag) else $error("tag read in cw");
	property p_pulse;
		tag_unique_valid && out_predefined && tag_read_enable && !read_all_mode && !wiegand_mode
			|-> ##2 (first_sense_output && second_sense_output);
	endproperty
	a_pulse: assert property (p_pulse) else $error("no sense pulse on tag");
	property p_no_pulse;
		$rose(first_sense_output) && out_predefined |-> $past(tag_unique_valid, 2)
			&& !$past(read_all_mode, 2) && !$past(wiegand_mode, 2);
	endproperty
	a_no_pulse: assert property (p_no_pulse) else $error("sense pulse without cause");
	property p_host_hold;
		!out_predefined && !$past(out_predefined) && !cmd_done && !$past(cmd_done)
			|-> $stable({first_sense_output, second_sense_output});
	endproperty
	a_host_hold: assert property (p_host_hold) else $error("outputs moved under host");
	property p_predef; $rose(out_predefined) |-> $past(cmd_done); endproperty
	a_predef: assert property (p_predef) else $error("predefined without command");
	property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
	property p_done_cr; cmd_done || cmd_error |-> $past(cr_seen, 2) || $past(cr_seen, 3); endproperty
	a_done_cr: assert property (p_done_cr) else $error("result without terminator");
	property p_report_mode; change_report |-> data_mode; endproperty
	a_report_mode: assert property (p_report_mode) else $error("report in command mode");
endmodule // rfio_ctrl_asserts

bind rfio_ctrl rfio_ctrl_asserts i_rfio_ctrl_asserts (.clock, .arst_n, .rx_byte, .rx_valid,
	.tag_unique_valid, .read_all_mode, .wiegand_mode, .reg_rd, .reg_rdata, .rf_enable, .rf_cw,
	.tag_read_enable, .first_sense_output, .second_sense_output, .data_mode, .change_report,
	.out_predefined, .cmd_done, .cmd_error);

// ---- testbench/rfio_host_model.sv ----
// host computer model driving serial characters and the clear-to-send line
`timescale 1ns/10ps
module rfio_host_model (
	// clock
	input  wire logic       clock,
	// serial characters and handshake
	output logic      [7:0] rx_byte,
	output logic            rx_valid,
	output logic            cts
);
	import rfio_pkg::*;
	// idle line, clear to send asserted
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		cts = 1'b1;
	end
	// one character for one edge, line inverted once released
	task automatic xchar(input logic [7:0] ch);
		rx_byte <= ch;
		rx_valid <= 1'b1;
		@(posedge clock);
		rx_byte <= ~ch;
		rx_valid <= 1'b0;
	endtask
	// start char, digits, carriage return
	task automatic send(input string s);
		rx_valid <= 1'b1;
		rx_byte <= CH_SOM;
		@(posedge clock);
		foreach (s[i]) begin
			rx_byte <= s[i];
			@(posedge clock);
		end
		xchar(CH_CR);
	endtask
	// hardware handshake level
	task automatic hold_cts(input logic v);
		cts <= v;
	endtask
endmodule // rfio_host_model

// ---- testbench/testbench.sv ----
// self-checking bench for the rf/io serial control block
`timescale 1ns/10ps
module testbench;
	import rfio_pkg::*;
	localparam int PU = 4;
	logic clock, arst_n, presence_input, auxiliary_input, tag_unique_valid;
	logic read_all_mode, wiegand_mode, reg_wr, reg_rd, cts, rx_valid;
	logic [7:0] rx_byte;
	logic [3:0] reg_addr, baud_sel, stop_sel, parity_sel;
	logic [31:0] reg_wdata, reg_rdata;
	logic rf_enable, rf_cw, tag_read_enable, first_sense_output, second_sense_output, tx_enable;
	logic data_mode, error_correcting_protocol, change_report, status_query, out_predefined;
	logic cmd_done, cmd_error;
	logic [1:0] inputs_true;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	string dcmd[4] = '{"6200", "6201", "6202", "6203"};
	logic [1:0] dexp[4] = '{2'b00, 2'b10, 2'b01, 2'b11};
	// pulse outputs watched by index
	wire logic [3:0] pulses = {cmd_error, change_report, status_query, cmd_done};
	rfio_ctrl #(.PULSE_UNIT(PU)) i_rfio_ctrl (.clock, .arst_n, .rx_byte, .rx_valid,
		.presence_input, .auxiliary_input, .cts, .tag_unique_valid, .read_all_mode,
		.wiegand_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rf_enable, .rf_cw,
		.tag_read_enable, .first_sense_output, .second_sense_output, .tx_enable, .data_mode,
		.error_correcting_protocol, .baud_sel, .stop_sel, .parity_sel, .change_report,
		.inputs_true, .status_query, .out_predefined, .cmd_done, .cmd_error);
	rfio_host_model i_rfio_host_model (.clock, .rx_byte, .rx_valid, .cts);
	// clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			$display("ERROR %0t timeout", $time);
			close_out();
		end
	end
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic cmd(input string s);
		i_rfio_host_model.send(s);
		tick(5);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, exp, what);
		@(posedge clock);
	endtask
	// watch one pulse output for ten cycles
	task automatic catch(input int idx, input logic exp, input string what);
		logic seen;
		seen = 1'b0;
		repeat (10) begin
			@(negedge clock);
			if (pulses[idx] === 1'b1) seen = 1'b1;
		end
		@(posedge clock);
		chk(seen, exp, what);
	endtask
	// one tag read, count cycles with both outputs high
	task automatic sense(input int exp);
		int n;
		n = 0;
		tag_unique_valid <= 1'b1;
		@(posedge clock);
		tag_unique_valid <= 1'b0;
		repeat (20) begin
			@(negedge clock);
			if ((first_sense_output & second_sense_output) === 1'b1) n++;
		end
		@(posedge clock);
		chk(n, exp, "sense pulse");
	endtask
	// main sequence
	initial begin
		{arst_n, presence_input, auxiliary_input, tag_unique_valid, read_all_mode} = 5'h0;
		{wiegand_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = 39'h0;
		tick(5);
		arst_n <= 1'b1;
		tick(4);
		rd(REG_SERIAL, {16'h0, DATA_BITS, PARITY_NONE, STOP_1, BAUD_9600}, "serial");
		rd(REG_CONFIG, 32'h0000a008, "config");
		rd(REG_CONTROL, 32'h1, "control");
		rd(REG_STATUS, 32'h00000040, "status reg");
		rd(4'h2, 32'h0, "unmapped");
		wr(REG_CONFIG, 32'hffffffff);
		rd(REG_CONFIG, 32'h0000a008, "read only");
		wr(REG_CONTROL, 32'h0);
		cmd("6401");
		chk(rf_enable, 1'b0, "ignored cmd");
		wr(REG_CONTROL, 32'h1);
		$display("test registers done");
		presence_input <= 1'b1;
		tick(5);
		chk(rf_enable, 1'b1, "rf by input");
		cmd("6400");
		chk(rf_enable, 1'b0, "rf off");
		presence_input <= 1'b0;
		cmd("6401");
		chk(rf_enable, 1'b1, "rf on");
		cmd("6402");
		chk({rf_cw, rf_enable, tag_read_enable}, 3'b110, "cw");
		cmd("6940");
		chk(rf_cw, 1'b1, "cw held");
		presence_input <= 1'b1;
		cmd("641");
		chk({rf_cw, rf_enable}, 2'b01, "back to input");
		$display("test rf done");
		{presence_input, auxiliary_input} <= 2'b01;
		tick(5);
		chk({rf_enable, inputs_true}, 3'b010, "aux only");
		cmd("6941");
		chk(inputs_true, 2'b01, "inverted");
		cmd("6940");
		auxiliary_input <= 1'b0;
		i_rfio_host_model.send("526");
		catch(1, 1'b1, "status");
		chk({out_predefined, second_sense_output, first_sense_output}, 3'b100, "codes");
		$display("test inputs done");
		cmd("671");
		sense(2 * PU);
		read_all_mode <= 1'b1;
		sense(0);
		{read_all_mode, wiegand_mode} <= 2'b01;
		sense(0);
		wiegand_mode <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			cmd(dcmd[i]);
			chk({out_predefined, second_sense_output, first_sense_output}, {1'b0, dexp[i]}, "direct");
		end
		cmd("6200");
		sense(0);
		cmd("621");
		chk(out_predefined, 1'b1, "predefined");
		$display("test outputs done");
		cmd("01");
		chk(data_mode, 1'b0, "command mode");
		cmd("1003");
		cmd("1011");
		cmd("1022");
		chk({parity_sel, stop_sel, baud_sel}, 12'h213, "port config");
		cmd("611");
		chk(error_correcting_protocol, 1'b1, "ecp");
		cmd("610");
		chk(error_correcting_protocol, 1'b0, "basic");
		cmd("00");
		cmd("1004");
		chk({data_mode, baud_sel}, 5'h14, "data mode change");
		$display("test serial done");
		i_rfio_host_model.xchar(CH_XOFF);
		tick(3);
		chk(tx_enable, 1'b0, "xoff");
		i_rfio_host_model.xchar(CH_XON);
		tick(3);
		chk(tx_enable, 1'b1, "xon");
		cmd("6142");
		i_rfio_host_model.hold_cts(1'b0);
		tick(5);
		chk(tx_enable, 1'b0, "cts low");
		i_rfio_host_model.hold_cts(1'b1);
		tick(5);
		chk(tx_enable, 1'b1, "cts high");
		cmd("6140");
		i_rfio_host_model.hold_cts(1'b0);
		tick(5);
		chk(tx_enable, 1'b1, "no flow");
		i_rfio_host_model.hold_cts(1'b1);
		cmd("6141");
		$display("test flow done");
		cmd("821");
		presence_input <= 1'b1;
		catch(2, 1'b1, "report presence");
		auxiliary_input <= 1'b1;
		catch(2, 1'b0, "aux not selected");
		cmd("823");
		cmd("01");
		presence_input <= 1'b0;
		catch(2, 1'b0, "no report in command mode");
		i_rfio_host_model.send("00");
		catch(0, 1'b1, "command done");
		i_rfio_host_model.send("999");
		catch(3, 1'b1, "bad command");
		$display("test reports done");
		close_out();
	end
endmodule // testbench
